// ==== logic/vic_pkg.sv ====
// Overview of operation
// R1 - pin and watchdog nonmaskable, codes 0010/0020
// R2 - 51 maskable sources, handler equals code
// R3 - each maskable source has a mask
// R4 - eight priority levels, best one presented
// R5 - only strictly higher level preempts service
// R6 - servicing starts at least 5 clocks later
// R7 - exceptions win over interrupts
// R8 - two trap channels, 004n and 005n
// R9 - bad opcode and debug trap share 0060
// R10 - pin filter, selectable edge, level mode
// R11 - nonmaskable and external zero share pin
// R12 - ties go to lowest default priority
// R13 - reset vectors to zero, code 0000
package vic_pkg;

  localparam int NUM_INT      = 45;
  localparam int NUM_EXT      = 4;
  localparam int NUM_SW       = 2;
  localparam int NUM_SRC      = NUM_INT + NUM_EXT + NUM_SW;
  localparam int NUM_SLOT     = NUM_SRC + 2;
  localparam int SLOT_W       = 6;
  localparam int LVL_W        = 3;
  localparam int NUM_LVL      = 8;
  localparam int EXT_SLOT0    = 3;
  localparam int NMI_PIN_SLOT = NUM_SRC;
  localparam int NMI_WDT_SLOT = NUM_SRC + 1;

  // latency floor in clocks; two stages are spent in capture and output
  localparam int MIN_LAT_CYC  = 5;
  localparam int PIPE_DEPTH   = MIN_LAT_CYC - 2;
  localparam int FILT_CYC     = 3;

  localparam logic [15:0] CODE_RESET    = 16'h0000;
  localparam logic [15:0] CODE_NMI_PIN  = 16'h0010;
  localparam logic [15:0] CODE_NMI_WDT  = 16'h0020;
  localparam logic [15:0] CODE_NMI_IDLE = 16'h0030;
  localparam logic [15:0] CODE_TRAP_A   = 16'h0040;
  localparam logic [15:0] CODE_TRAP_B   = 16'h0050;
  localparam logic [15:0] CODE_BAD_OP   = 16'h0060;
  localparam logic [15:0] CODE_IRQ_BASE = 16'h0080;
  localparam logic [31:0] HND_RESET     = 32'h0000_0000;
  localparam logic [31:0] HND_TRAP_A    = 32'h0000_0040;
  localparam logic [31:0] HND_TRAP_B    = 32'h0000_0050;
  localparam logic [31:0] HND_BAD_OP    = 32'h0000_0060;

  localparam int         EDGE_RISE_BIT = 0;
  localparam int         EDGE_FALL_BIT = 1;
  localparam logic [1:0] EDGE_FALL     = 2'h2;

  typedef enum logic [1:0] {VK_RESET, VK_NMI, VK_EXC, VK_IRQ} vec_kind_t;

  // fixed default priority per maskable slot, slots ordered by it
  localparam logic [6:0] DEF_PRIO [NUM_SRC] = '{
    7'h02, 7'h03, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12,
    7'h13, 7'h14, 7'h15, 7'h1f, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28,
    7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37,
    7'h38, 7'h39, 7'h3a, 7'h3b, 7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h46, 7'h47, 7'h59, 7'h5a};

  function automatic logic [15:0] irq_code(input logic [SLOT_W-1:0] s);
    irq_code = CODE_IRQ_BASE + {5'h00, DEF_PRIO[s], 4'h0}; // [R2]
  endfunction : irq_code

  // level 0 is the most urgent
  function automatic logic [LVL_W-1:0] first_set(input logic [NUM_LVL-1:0] v);
    first_set = '0;
    for (int i = NUM_LVL - 1; i >= 0; i--) begin
      if (v[i]) first_set = LVL_W'(i);
    end
  endfunction : first_set

endpackage : vic_pkg

// ==== logic/ext_req_filter.sv ====
`timescale 1ns/1ns
module ext_req_filter import vic_pkg::*; (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // pin and its setup
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  input  wire logic       level_mode,
  // request towards the controller
  output logic            evt
);

  logic [1:0]          sync_q, sync_d;
  logic [FILT_CYC-1:0] hist_q, hist_d;
  logic                filt_q, filt_d;
  logic                prev_q, prev_d;
  logic                evt_q, evt_d;
  logic                act_low;

  always_comb begin
    sync_d  = {sync_q[0], pin};
    hist_d  = {hist_q[FILT_CYC-2:0], sync_q[1]};
    // a level must hold for the whole window to be believed
    filt_d  = (&hist_q) ? 1'b1 : ((~|hist_q) ? 1'b0 : filt_q); // [R10]
    prev_d  = filt_q;
    act_low = (edge_sel == EDGE_FALL);
    if (level_mode) begin
      evt_d = filt_q ^ act_low; // [R10]
    end else begin
      evt_d = (edge_sel[EDGE_RISE_BIT] & filt_q & ~prev_q) | (edge_sel[EDGE_FALL_BIT] & ~filt_q & prev_q); // [R10]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_q <= '0;
      hist_q <= '0;
      filt_q <= 1'b0;
      prev_q <= 1'b0;
      evt_q  <= 1'b0;
    end else begin
      sync_q <= sync_d;
      hist_q <= hist_d;
      filt_q <= filt_d;
      prev_q <= prev_d;
      evt_q  <= evt_d;
    end
  end

  assign evt = evt_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  AST_EDGE_ONE_PULSE: assert property ((!level_mode && $stable(level_mode) && evt_q) |=> !evt_q) // [R10]
    else $error("edge event lasted more than one cycle");

endmodule : ext_req_filter

// ==== logic/vectored_irq_unit.sv ====
`timescale 1ns/1ns
module vectored_irq_unit import vic_pkg::*; (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     srst,
  // request sources
  input  wire logic [NUM_INT-1:0]       periph_req,
  input  wire logic [NUM_SW-1:0]        soft_req,
  input  wire logic [NUM_EXT-1:0]       ext_pin,
  input  wire logic                     watchdog_nonmaskable_req,
  // configuration
  input  wire logic                     pin0_is_nmi,
  input  wire logic [NUM_SRC-1:0]       irq_mask,
  input  wire logic [NUM_SRC*LVL_W-1:0] irq_prio,
  input  wire logic [2*NUM_EXT-1:0]     ext_edge_sel,
  input  wire logic [NUM_EXT-1:0]       ext_level_mode,
  // exceptions from the core
  input  wire logic                     soft_trap_channel_a,
  input  wire logic                     soft_trap_channel_b,
  input  wire logic [3:0]               trap_num,
  input  wire logic                     bad_opcode_trap,
  input  wire logic                     debug_trap_instr,
  // core handshake
  input  wire logic                     vec_ack,
  input  wire logic                     serv_end,
  output vec_kind_t                     vec_kind,
  output logic                          vec_valid,
  output logic [15:0]                   vec_code,
  output logic [31:0]                   vec_handler,
  output logic [LVL_W-1:0]              vec_level
);

  logic [NUM_EXT-1:0]  ext_evt;
  logic                pin_nonmaskable_req;
  logic                external_req_zero;
  logic [NUM_SLOT-1:0] set_vec, clr_vec, ripe, mask_pad;
  logic [NUM_SLOT-1:0] pend_q, pend_d;
  logic [NUM_SLOT-1:0] pipe_q [PIPE_DEPTH];
  logic [NUM_SLOT-1:0] pipe_d [PIPE_DEPTH];
  logic [NUM_LVL-1:0]  isr_q, isr_d;
  logic                nmi_isr_q, nmi_isr_d;
  logic                exc_v_q, exc_v_d;
  logic [15:0]         exc_code_q, exc_code_d;
  logic [31:0]         exc_hnd_q, exc_hnd_d;
  logic                reset_vec_q, reset_vec_d;
  logic                vec_valid_q, vec_valid_d;
  vec_kind_t           vec_kind_q, vec_kind_d;
  logic [15:0]         vec_code_q, vec_code_d;
  logic [31:0]         vec_handler_q, vec_handler_d;
  logic [LVL_W-1:0]    vec_level_q, vec_level_d;
  logic [SLOT_W-1:0]   sel_q, sel_d;
  logic                sel_masked_q, sel_masked_d;
  logic                best_found, any_isr, irq_ok, nmi_ok, taken;
  logic [SLOT_W-1:0]   best_idx;
  logic [LVL_W-1:0]    best_prio, cur_lvl;

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_pin
      ext_req_filter u_filt (
        .mclk       (mclk),
        .srst       (srst),
        .pin        (ext_pin[g]),
        .edge_sel   (ext_edge_sel[2*g +: 2]),
        .level_mode (ext_level_mode[g]),
        .evt        (ext_evt[g])
      );
    end
  endgenerate

  // one pin, two jobs, chosen by configuration
  assign pin_nonmaskable_req = pin0_is_nmi & ext_evt[0];  // [R11]
  assign external_req_zero   = ~pin0_is_nmi & ext_evt[0]; // [R11]
  assign set_vec  = {watchdog_nonmaskable_req, pin_nonmaskable_req, periph_req[44:43], soft_req,
                     periph_req[42:3], ext_evt[3:1], external_req_zero, periph_req[2:0]}; // [R1] [R2]
  assign mask_pad = {2'b00, irq_mask};
  assign taken    = vec_ack & vec_valid_q;

  // arbitration
  always_comb begin
    ripe       = pipe_q[PIPE_DEPTH-1] & pend_q;
    best_found = 1'b0;
    best_idx   = '0;
    best_prio  = '1;
    for (int i = 0; i < NUM_SRC; i++) begin
      // strict compare keeps the lower slot on a tie
      if (ripe[i] && !irq_mask[i] && (!best_found || irq_prio[i*LVL_W +: LVL_W] < best_prio)) begin // [R3] [R4] [R12]
        best_found = 1'b1;
        best_idx   = SLOT_W'(i);
        best_prio  = irq_prio[i*LVL_W +: LVL_W];
      end
    end
    cur_lvl = first_set(isr_q);
    any_isr = |isr_q;
    irq_ok  = best_found && !nmi_isr_q && (!any_isr || best_prio < cur_lvl); // [R5]
    nmi_ok  = !nmi_isr_q && (ripe[NMI_PIN_SLOT] || ripe[NMI_WDT_SLOT]);    // [R1]
  end

  // presented vector
  always_comb begin
    vec_valid_d   = 1'b0;
    vec_kind_d    = vec_kind_q;
    vec_code_d    = vec_code_q;
    vec_handler_d = vec_handler_q;
    vec_level_d   = vec_level_q;
    sel_d         = sel_q;
    if (reset_vec_q) begin
      vec_valid_d   = 1'b1;
      vec_kind_d    = VK_RESET;
      vec_code_d    = CODE_RESET;
      vec_handler_d = HND_RESET; // [R13]
    end else if (exc_v_q) begin
      vec_valid_d   = 1'b1;
      vec_kind_d    = VK_EXC; // [R7]
      vec_code_d    = exc_code_q;
      vec_handler_d = exc_hnd_q;
    end else if (nmi_ok) begin
      vec_valid_d   = 1'b1;
      vec_kind_d    = VK_NMI;
      sel_d         = ripe[NMI_PIN_SLOT] ? SLOT_W'(NMI_PIN_SLOT) : SLOT_W'(NMI_WDT_SLOT);
      vec_code_d    = ripe[NMI_PIN_SLOT] ? CODE_NMI_PIN : CODE_NMI_WDT; // [R1]
      vec_handler_d = {16'h0000, vec_code_d};
      vec_level_d   = '0;
    end else if (irq_ok) begin
      vec_valid_d   = 1'b1;
      vec_kind_d    = VK_IRQ;
      sel_d         = best_idx;
      vec_code_d    = irq_code(best_idx);
      vec_handler_d = {16'h0000, vec_code_d}; // [R2]
      vec_level_d   = best_prio;
    end
    // a one-cycle gap after a take, so a stale vector is never taken twice
    if (taken) vec_valid_d = 1'b0;
    sel_masked_d = (vec_kind_d == VK_IRQ) && mask_pad[sel_d];
  end

  // pending, in-service and exception state
  always_comb begin
    pend_d      = pend_q;
    isr_d       = isr_q;
    nmi_isr_d   = nmi_isr_q;
    exc_v_d     = exc_v_q;
    exc_code_d  = exc_code_q;
    exc_hnd_d   = exc_hnd_q;
    reset_vec_d = reset_vec_q;
    clr_vec     = '0;
    if (serv_end) begin
      if (nmi_isr_q) nmi_isr_d = 1'b0;
      else if (any_isr) isr_d[cur_lvl] = 1'b0; // [R5]
    end
    if (taken) begin
      case (vec_kind_q)
        VK_RESET: reset_vec_d = 1'b0;
        VK_EXC:   exc_v_d = 1'b0;
        VK_NMI: begin
          clr_vec[sel_q] = 1'b1;
          nmi_isr_d      = 1'b1;
        end
        VK_IRQ: begin
          clr_vec[sel_q]     = 1'b1;
          isr_d[vec_level_q] = 1'b1; // [R5]
        end
        default: ;
      endcase
    end
    // a new request in the take cycle survives
    pend_d = (pend_q & ~clr_vec) | set_vec;
    pipe_d[0] = pend_q & ~clr_vec;
    for (int k = 1; k < PIPE_DEPTH; k++) begin
      pipe_d[k] = pipe_q[k-1] & pend_q & ~clr_vec; // [R6]
    end
    if (!exc_v_d) begin
      if (bad_opcode_trap || debug_trap_instr) begin
        exc_v_d    = 1'b1;
        exc_code_d = CODE_BAD_OP;
        exc_hnd_d  = HND_BAD_OP; // [R9]
      end else if (soft_trap_channel_a) begin
        exc_v_d    = 1'b1;
        exc_code_d = CODE_TRAP_A | {12'h000, trap_num};
        exc_hnd_d  = HND_TRAP_A; // [R8]
      end else if (soft_trap_channel_b) begin
        exc_v_d    = 1'b1;
        exc_code_d = CODE_TRAP_B | {12'h000, trap_num};
        exc_hnd_d  = HND_TRAP_B; // [R8]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_q        <= '0;
      pipe_q        <= '{default: '0};
      isr_q         <= '0;
      nmi_isr_q     <= 1'b0;
      exc_v_q       <= 1'b0;
      exc_code_q    <= CODE_RESET;
      exc_hnd_q     <= HND_RESET;
      reset_vec_q   <= 1'b1; // [R13]
      vec_valid_q   <= 1'b1;
      vec_kind_q    <= VK_RESET;
      vec_code_q    <= CODE_RESET;
      vec_handler_q <= HND_RESET;
      vec_level_q   <= '0;
      sel_q         <= '0;
      sel_masked_q  <= 1'b0;
    end else begin
      pend_q        <= pend_d;
      pipe_q        <= pipe_d;
      isr_q         <= isr_d;
      nmi_isr_q     <= nmi_isr_d;
      exc_v_q       <= exc_v_d;
      exc_code_q    <= exc_code_d;
      exc_hnd_q     <= exc_hnd_d;
      reset_vec_q   <= reset_vec_d;
      vec_valid_q   <= vec_valid_d;
      vec_kind_q    <= vec_kind_d;
      vec_code_q    <= vec_code_d;
      vec_handler_q <= vec_handler_d;
      vec_level_q   <= vec_level_d;
      sel_q         <= sel_d;
      sel_masked_q  <= sel_masked_d;
    end
  end

  assign vec_valid   = vec_valid_q;
  assign vec_kind    = vec_kind_q;
  assign vec_code    = vec_code_q;
  assign vec_handler = vec_handler_q;
  assign vec_level   = vec_level_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  logic irq_out, slot0_out;
  assign irq_out   = vec_valid_q && (vec_kind_q == VK_IRQ);
  assign slot0_out = irq_out && (sel_q == '0);

  AST_NMI_CODE: assert property ((vec_valid_q && vec_kind_q == VK_NMI) |->
    (vec_code_q == CODE_NMI_PIN || vec_code_q == CODE_NMI_WDT) && vec_handler_q == {16'h0000, vec_code_q}) // [R1]
    else $error("nonmaskable vector has a wrong code");
  AST_IRQ_HANDLER: assert property (irq_out |->
    vec_handler_q == {16'h0000, vec_code_q} && vec_code_q >= CODE_IRQ_BASE && vec_code_q[3:0] == 4'h0) // [R2]
    else $error("maskable handler differs from its code");
  AST_MASKED_HELD: assert property (irq_out |-> !sel_masked_q) // [R3]
    else $error("a masked request reached the core");
  AST_LEVEL_OUT: assert property (irq_out |-> vec_level_q == $past(irq_prio[sel_d*LVL_W +: LVL_W])) // [R4]
    else $error("presented level differs from the chosen source");
  AST_PREEMPT: assert property ((irq_out && $past(any_isr)) |-> vec_level_q < $past(cur_lvl)) // [R5]
    else $error("request preempted without strictly higher level");
  AST_MIN_LAT: assert property ($rose(pend_q[0]) |-> (!slot0_out) [*4]) // [R6]
    else $error("request serviced before the latency floor");
  AST_EXC_FIRST: assert property ((exc_v_q && !reset_vec_q && !vec_ack) |=>
    (vec_valid_q && vec_kind_q == VK_EXC)) // [R7]
    else $error("exception not presented ahead of interrupts");
  AST_TRAP_HND: assert property ((vec_valid_q && vec_kind_q == VK_EXC && vec_code_q[15:4] != CODE_BAD_OP[15:4]) |->
    vec_handler_q == {16'h0000, vec_code_q[15:4], 4'h0}) // [R8]
    else $error("trap handler does not match its channel");
  AST_BAD_OP: assert property (((bad_opcode_trap || debug_trap_instr) && !exc_v_q) |=>
    (exc_v_q && exc_code_q == CODE_BAD_OP && exc_hnd_q == HND_BAD_OP)) // [R9]
    else $error("bad opcode trap not captured");
  AST_SHARED_PIN: assert property ((pin0_is_nmi && !pend_q[EXT_SLOT0] && !ext_evt[0]) |=>
    !pend_q[EXT_SLOT0]) // [R11]
    else $error("external zero raised while pin is nonmaskable");
  AST_RESET_VEC: assert property ($past(srst) |-> vec_valid_q && vec_kind_q == VK_RESET &&
    vec_code_q == CODE_RESET && vec_handler_q == HND_RESET) // [R13]
    else $error("reset vector not presented after reset");

  COV_NMI: cover property (vec_valid_q && vec_kind_q == VK_NMI && vec_ack);
  COV_NEST: cover property (irq_out && any_isr && vec_ack);
  COV_TRAP: cover property (vec_valid_q && vec_kind_q == VK_EXC && vec_ack);

endmodule : vectored_irq_unit

// ==== verif/core_model.sv ====
`timescale 1ns/1ns
// core side of the vector port: takes a standing vector after a set wait
module core_model import vic_pkg::*; (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // vector port
  input  wire logic             vec_valid,
  input  wire logic [15:0]      vec_code,
  input  wire logic [31:0]      vec_handler,
  input  vec_kind_t             vec_kind,
  input  wire logic [LVL_W-1:0] vec_level,
  output logic                  vec_ack,
  // bench control
  input  wire logic             ack_en,
  input  wire logic [3:0]       ack_wait,
  output logic                  took,
  output logic [15:0]           took_code,
  output logic [31:0]           took_hnd,
  output logic [LVL_W-1:0]      took_level,
  output vec_kind_t             took_kind
);
  logic [3:0] wait_q;
  logic       en_q;

  // enable sampled on the rising edge, avoids a race with the bench
  always @(posedge mclk) begin
    took <= 1'b0;
    en_q <= ack_en;
    if (srst) begin
      wait_q <= 4'h0;
    end else if (vec_valid && vec_ack) begin
      took      <= 1'b1;
      took_code <= vec_code;
      took_hnd  <= vec_handler;
      took_kind <= vec_kind;
      took_level <= vec_level;
      wait_q    <= 4'h0;
    end else if (vec_valid && en_q) begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // ack drops for a cycle after each take, never two takes of one vector
  always @(negedge mclk) begin
    vec_ack <= !srst && en_q && vec_valid && !vec_ack && wait_q >= ack_wait;
  end
endmodule : core_model

// ==== verif/test_vectored_irq_unit.sv ====
`timescale 1ns/1ns
module test_vectored_irq_unit import vic_pkg::*; ();
  logic                     mclk, srst, watchdog_nonmaskable_req, pin0_is_nmi;
  logic [NUM_INT-1:0]       periph_req;
  logic [NUM_SW-1:0]        soft_req;
  logic [NUM_EXT-1:0]       ext_pin, ext_level_mode;
  logic [NUM_SRC-1:0]       irq_mask;
  logic [NUM_SRC*LVL_W-1:0] irq_prio;
  logic [2*NUM_EXT-1:0]     ext_edge_sel;
  logic                     soft_trap_channel_a, soft_trap_channel_b, bad_opcode_trap, debug_trap_instr;
  logic [3:0]               trap_num, ack_wait;
  logic                     vec_ack, serv_end, vec_valid, ack_en, took;
  vec_kind_t                vec_kind, took_kind;
  logic [15:0]              vec_code, took_code;
  logic [31:0]              vec_handler, took_hnd;
  logic [LVL_W-1:0]         vec_level, took_level;
  int                       miscompares, comparisons, cyc;

  vectored_irq_unit dut_u (.mclk(mclk), .srst(srst), .periph_req(periph_req), .soft_req(soft_req),
    .ext_pin(ext_pin), .watchdog_nonmaskable_req(watchdog_nonmaskable_req), .pin0_is_nmi(pin0_is_nmi),
    .irq_mask(irq_mask), .irq_prio(irq_prio), .ext_edge_sel(ext_edge_sel), .ext_level_mode(ext_level_mode),
    .soft_trap_channel_a(soft_trap_channel_a), .soft_trap_channel_b(soft_trap_channel_b),
    .trap_num(trap_num), .bad_opcode_trap(bad_opcode_trap), .debug_trap_instr(debug_trap_instr),
    .vec_ack(vec_ack), .serv_end(serv_end), .vec_kind(vec_kind), .vec_valid(vec_valid),
    .vec_code(vec_code), .vec_handler(vec_handler), .vec_level(vec_level));

  core_model core_u (.mclk(mclk), .srst(srst), .vec_valid(vec_valid), .vec_code(vec_code),
    .vec_handler(vec_handler), .vec_kind(vec_kind), .vec_level(vec_level), .vec_ack(vec_ack), .ack_en(ack_en),
    .ack_wait(ack_wait), .took(took), .took_code(took_code), .took_hnd(took_hnd), .took_level(took_level),
    .took_kind(took_kind));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // hang guard, whole run is a few hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic done_srv;
    serv_end = 1'b1;
    @(negedge mclk);
    serv_end = 1'b0;
  endtask : done_srv

  // let the core take the next vector, compare it, optionally end service
  task automatic take(input vec_kind_t k, input logic [15:0] c, input logic [31:0] h, input logic fin);
    int n;
    n = 0;
    ack_en = 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (took !== 1'b1 && n < 60);
    ack_en = 1'b0;
    chk({31'h0, took}, 32'h1, "taken");
    chk(32'(took_kind), 32'(k), "kind");
    chk({16'h0, took_code}, {16'h0, c}, "code");
    chk(took_hnd, h, "handler");
    if (fin) done_srv();
  endtask : take

  task automatic preq(input int a, input int b);
    periph_req[a] = 1'b1;
    periph_req[b] = 1'b1;
    @(negedge mclk);
    periph_req = '0;
  endtask : preq

  // idle must hold on every cycle of the window, not only at its end
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge mclk);
      seen = seen | vec_valid;
    end
    chk({31'h0, seen}, 32'h0, "idle");
  endtask : quiet

  task automatic lvl(input int s, input logic [2:0] v);
    irq_prio[s*LVL_W +: LVL_W] = v;
  endtask : lvl

  task automatic t_latency;
    int n;
    preq(0, 0);
    n = 1;
    while (vec_valid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(n), 32'h5, "latency");
    take(VK_IRQ, 16'h00a0, 32'h000000a0, 1'b1);
    soft_req[1] = 1'b1;
    @(negedge mclk);
    soft_req[1] = 1'b0;
    take(VK_IRQ, 16'h04f0, 32'h000004f0, 1'b1);
    irq_mask[0] = 1'b1;
    preq(0, 0);
    quiet(12);
    irq_mask[0] = 1'b0;
    take(VK_IRQ, 16'h00a0, 32'h000000a0, 1'b1);
    $display("test latency and mask done");
  endtask : t_latency

  task automatic t_prio;
    ack_wait = 4'h3;
    lvl(1, 3'h2);
    lvl(2, 3'h1);
    preq(1, 2);
    take(VK_IRQ, 16'h00d0, 32'h000000d0, 1'b1);
    chk(32'(took_level), 32'h1, "level");
    take(VK_IRQ, 16'h00b0, 32'h000000b0, 1'b1);
    chk(32'(took_level), 32'h2, "level");
    ack_wait = 4'h0;
    lvl(1, 3'h7);
    lvl(2, 3'h7);
    preq(2, 1);
    take(VK_IRQ, 16'h00b0, 32'h000000b0, 1'b1);
    take(VK_IRQ, 16'h00d0, 32'h000000d0, 1'b1);
    $display("test priority done");
  endtask : t_prio

  task automatic t_nest;
    lvl(0, 3'h3);
    lvl(1, 3'h3);
    lvl(2, 3'h2);
    preq(0, 0);
    take(VK_IRQ, 16'h00a0, 32'h000000a0, 1'b0);
    preq(1, 1);
    quiet(12);
    preq(2, 2);
    take(VK_IRQ, 16'h00d0, 32'h000000d0, 1'b1);
    chk(32'(took_level), 32'h2, "level");
    quiet(12);
    done_srv();
    take(VK_IRQ, 16'h00b0, 32'h000000b0, 1'b1);
    irq_prio = '1;
    $display("test nesting done");
  endtask : t_nest

  task automatic t_nmi;
    irq_mask = '1;
    watchdog_nonmaskable_req = 1'b1;
    @(negedge mclk);
    watchdog_nonmaskable_req = 1'b0;
    take(VK_NMI, 16'h0020, 32'h00000020, 1'b1);
    chk(32'(took_level), 32'h0, "level");
    pin0_is_nmi = 1'b1;
    ext_pin[0] = 1'b1;
    take(VK_NMI, 16'h0010, 32'h00000010, 1'b1);
    ext_pin[0] = 1'b0;
    pin0_is_nmi = 1'b0;
    irq_mask = '0;
    repeat (10) @(negedge mclk);
    ext_pin[0] = 1'b1;
    take(VK_IRQ, 16'h00e0, 32'h000000e0, 1'b1);
    ext_pin[0] = 1'b0;
    $display("test nonmaskable done");
  endtask : t_nmi

  task automatic t_exc;
    preq(0, 0);
    repeat (6) @(negedge mclk);
    soft_trap_channel_a = 1'b1;
    trap_num = 4'h5;
    @(negedge mclk);
    soft_trap_channel_a = 1'b0;
    repeat (3) @(negedge mclk);
    take(VK_EXC, 16'h0045, 32'h00000040, 1'b0);
    @(negedge mclk);
    take(VK_IRQ, 16'h00a0, 32'h000000a0, 1'b1);
    for (int i = 0; i < 32; i++) begin
      soft_trap_channel_a = (i < 16);
      soft_trap_channel_b = (i >= 16);
      trap_num = 4'(i);
      @(negedge mclk);
      soft_trap_channel_a = 1'b0;
      soft_trap_channel_b = 1'b0;
      take(VK_EXC, 16'h0040 + 16'(i), 32'h00000040 | 32'(i & 16), 1'b0);
    end
    bad_opcode_trap = 1'b1;
    @(negedge mclk);
    bad_opcode_trap = 1'b0;
    take(VK_EXC, 16'h0060, 32'h00000060, 1'b0);
    debug_trap_instr = 1'b1;
    @(negedge mclk);
    debug_trap_instr = 1'b0;
    take(VK_EXC, 16'h0060, 32'h00000060, 1'b0);
    $display("test exceptions done");
  endtask : t_exc

  // level pin left pending at the end, so this runs just before the mid-run reset
  task automatic t_ext;
    ext_edge_sel[3:2] = 2'h2;
    ext_pin[1] = 1'b1;
    quiet(20);
    ext_pin[1] = 1'b0;
    take(VK_IRQ, 16'h00f0, 32'h000000f0, 1'b1);
    ext_edge_sel[5:4] = 2'h3;
    ext_pin[2] = 1'b1;
    take(VK_IRQ, 16'h0100, 32'h00000100, 1'b1);
    ext_pin[2] = 1'b0;
    take(VK_IRQ, 16'h0100, 32'h00000100, 1'b1);
    ext_level_mode[3] = 1'b1;
    ext_pin[3] = 1'b1;
    take(VK_IRQ, 16'h0110, 32'h00000110, 1'b1);
    take(VK_IRQ, 16'h0110, 32'h00000110, 1'b1);
    $display("test external pins done");
  endtask : t_ext

  // reset in mid-run must drop all pending work and present the reset vector
  task automatic t_reset;
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    take(VK_RESET, 16'h0000, 32'h00000000, 1'b0);
    $display("test mid-run reset done");
  endtask : t_reset

  initial begin
    {srst, ack_en, serv_end} = 3'h4;
    {watchdog_nonmaskable_req, pin0_is_nmi, soft_trap_channel_a, soft_trap_channel_b} = 4'h0;
    {bad_opcode_trap, debug_trap_instr, trap_num, ack_wait} = 10'h000;
    {periph_req, soft_req, ext_pin, ext_level_mode, irq_mask} = '0;
    irq_prio = '1;
    ext_edge_sel = 8'h55;
    {miscompares, comparisons, cyc} = '0;
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    take(VK_RESET, 16'h0000, 32'h00000000, 1'b0);
    t_latency();
    t_prio();
    t_nest();
    t_nmi();
    t_exc();
    t_ext();
    t_reset();
    stop_test();
  end
endmodule : test_vectored_irq_unit
